/* inc/endpoint_halt_pkg.sv */
package endpoint_halt_pkg;
	localparam int NUM_EP = 6;
	localparam int EP_ID_W = 3;
	localparam int WB_ADR_W = 4;
	localparam int WB_DAT_W = 32;
	localparam int WB_SEL_W = 4;
	localparam int REG_W = 8;

	// Byte addresses of the word-aligned registers
	localparam logic [3:0] HALT_CTRL_OFF = 4'h0;
	localparam logic [3:0] HALT_CFG_OFF = 4'h4;
	localparam logic [3:0] HALT_STATE_OFF = 4'h8;

	localparam logic [7:0] HALT_CTRL_RESET = 8'h00;
	localparam logic [7:0] HALT_CTRL_RSVD_MASK = 8'h82;
	localparam logic [0:0] HALT_CFG_RESET = 1'h0;
	localparam logic [5:0] HALT_STATE_RESET = 6'h00;

	// Field positions
	localparam int EP0_HALT_POS = 0;
	localparam int EPN_HALT_SHIFT = 1;
	localparam int AUTOCLEAR_POS = 0;
	localparam int BYTE_LANE0 = 0;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RESPOND = 1'b1
	} resp_state_t;

	typedef struct packed {
		logic valid;
		logic setup;
		logic [EP_ID_W-1:0] ep;
	} token_t;

	typedef struct packed {
		logic valid;
		logic set;
		logic [EP_ID_W-1:0] ep;
	} feature_t;
endpackage

/* rtl/halt_bit_cell.sv */
module halt_bit_cell #(
	parameter bit ZERO_WRITE_OK = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic wbit_i,
	input wire logic hw_clear_i,
	input wire logic feat_clr_i,
	input wire logic feat_set_i,
	input wire logic stall_sent_i,
	output logic halt_o,
	output logic internal_o
);
	logic halt_reg;
	logic halt_next;
	logic armed_reg;
	logic armed_next;
	logic internal_reg;
	logic internal_next;
	logic set_ok;

	assign set_ok = wr_i & wbit_i & armed_reg;

	always_comb begin
		halt_next = halt_reg;
		armed_next = armed_reg;
		internal_next = internal_reg;
		// Hardware and host clears first so a software write in the same cycle is not lost
		// ClearFeature cancels stall
		if (hw_clear_i | feat_clr_i) begin
			halt_next = 1'b0;
		end
		if (set_ok) begin
			halt_next = 1'b1;
		end else if (wr_i & ~wbit_i & ZERO_WRITE_OK) begin
			halt_next = 1'b0;
		end
		if (rd_i) begin
			armed_next = ~halt_reg;
		end else if (wr_i) begin
			armed_next = 1'b0;
		end
		if (feat_clr_i) begin
			internal_next = 1'b0;
		end
		// STALL sent marks internal state; set wins
		if (feat_set_i | stall_sent_i) begin
			internal_next = 1'b1;
		end
		if (soft_rst_i) begin
			halt_next = 1'b0;
			armed_next = 1'b0;
			internal_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_reg <= 1'b0;
			armed_reg <= 1'b0;
			internal_reg <= 1'b0;
		end else begin
			halt_reg <= halt_next;
			armed_reg <= armed_next;
			internal_reg <= internal_next;
		end
	end

	assign halt_o = halt_reg;
	assign internal_o = internal_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence zero_read_then_set;
		rd_i && !halt_reg && !soft_rst_i ##1 (!rd_i && !wr_i && !soft_rst_i)[*2]
			##1 wr_i && wbit_i && !soft_rst_i;
	endsequence

	arm_gate_a: assert property ($rose(halt_reg) |-> $past(set_ok))
		else $error("halt bit set without a prior zero read");
	armed_set_a: assert property (zero_read_then_set |=> halt_reg)
		else $error("armed write of one did not set halt bit");
	zero_write_a: assert property (wr_i && !wbit_i && !ZERO_WRITE_OK && !hw_clear_i && !feat_clr_i && !soft_rst_i
		|=> $stable(halt_reg))
		else $error("zero write changed endpoint 0 halt bit");
	feature_clear_a: assert property (feat_clr_i && !set_ok && !feat_set_i && !stall_sent_i
		|=> !halt_reg && !internal_reg)
		else $error("ClearFeature left endpoint stalled");
	internal_set_a: assert property (stall_sent_i && !soft_rst_i |=> internal_reg)
		else $error("internal halt state not set after STALL");
endmodule

/* rtl/endpoint_stall_control.sv */
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
module endpoint_stall_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [endpoint_halt_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [endpoint_halt_pkg::WB_SEL_W-1:0] wb_sel_i,
	input wire logic [endpoint_halt_pkg::WB_DAT_W-1:0] wb_dat_i,
	output logic [endpoint_halt_pkg::WB_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire endpoint_halt_pkg::token_t token_i,
	input wire endpoint_halt_pkg::feature_t feature_i,
	output logic resp_valid_o,
	output logic resp_stall_o,
	output logic [endpoint_halt_pkg::EP_ID_W-1:0] resp_ep_o,
	output logic [endpoint_halt_pkg::REG_W-1:0] halt_bits_o,
	output logic [endpoint_halt_pkg::NUM_EP-1:0] ep_stalled_o
);
	localparam int NUM_EP = endpoint_halt_pkg::NUM_EP;
	localparam int EP_ID_W = endpoint_halt_pkg::EP_ID_W;
	localparam int REG_W = endpoint_halt_pkg::REG_W;
	localparam int DAT_W = endpoint_halt_pkg::WB_DAT_W;

	function automatic int halt_pos(input int ep);
		halt_pos = (ep == 0) ? endpoint_halt_pkg::EP0_HALT_POS : ep + endpoint_halt_pkg::EPN_HALT_SHIFT;
	endfunction

	// One-hot register mask of an endpoint; unknown endpoints give zero
	function automatic logic [REG_W-1:0] ep_mask(input logic [EP_ID_W-1:0] ep);
		logic [REG_W-1:0] m;
		m = '0;
		if (int'(ep) < NUM_EP) begin
			m[halt_pos(int'(ep))] = 1'b1;
		end
		ep_mask = m;
	endfunction

	// Reserved positions never carry a bit
	function automatic logic [REG_W-1:0] pack_halt(input logic [NUM_EP-1:0] h);
		logic [REG_W-1:0] b;
		b = '0;
		for (int i = 0; i < NUM_EP; i++) begin
			b[halt_pos(i)] = h[i];
		end
		pack_halt = b & ~endpoint_halt_pkg::HALT_CTRL_RSVD_MASK;
	endfunction

	// Register bus
	logic ack_reg;
	logic ack_next;
	logic [DAT_W-1:0] dat_reg;
	logic [DAT_W-1:0] dat_next;
	logic autoclear_reg;
	logic autoclear_next;
	logic wb_take;
	logic sel_halt;
	logic sel_cfg;
	logic sel_state;
	logic halt_wr;
	logic halt_rd;
	logic cfg_wr;

	// Endpoint cells
	logic [NUM_EP-1:0] halt_vec;
	logic [NUM_EP-1:0] internal_vec;
	logic [REG_W-1:0] halt_byte;

	// Token responder
	endpoint_halt_pkg::resp_state_t state_reg;
	endpoint_halt_pkg::resp_state_t state_next;
	logic resp_valid_reg;
	logic resp_valid_next;
	logic resp_stall_reg;
	logic resp_stall_next;
	logic [EP_ID_W-1:0] resp_ep_reg;
	logic [EP_ID_W-1:0] resp_ep_next;
	logic tok_take;
	logic [REG_W-1:0] tok_mask;
	logic stall_now;
	logic setup_ep0;
	logic [REG_W-1:0] feat_mask;

	assign halt_byte = pack_halt(halt_vec);

	// Single-cycle classic slave; ack low for one cycle between requests
	assign wb_take = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign sel_halt = wb_adr_i == endpoint_halt_pkg::HALT_CTRL_OFF;
	assign sel_cfg = wb_adr_i == endpoint_halt_pkg::HALT_CFG_OFF;
	assign sel_state = wb_adr_i == endpoint_halt_pkg::HALT_STATE_OFF;
	// Write only through the low byte lane where the fields live
	assign halt_wr = wb_take & wb_we_i & sel_halt & wb_sel_i[endpoint_halt_pkg::BYTE_LANE0];
	// Reads arm the set gate whatever the byte enables
	assign halt_rd = wb_take & ~wb_we_i & sel_halt;
	assign cfg_wr = wb_take & wb_we_i & sel_cfg & wb_sel_i[endpoint_halt_pkg::BYTE_LANE0];

	always_comb begin
		ack_next = wb_take;
		dat_next = dat_reg;
		autoclear_next = autoclear_reg;
		if (wb_take & ~wb_we_i) begin
			dat_next = '0;
			if (sel_halt) begin
				dat_next[REG_W-1:0] = halt_byte;
			end else if (sel_cfg) begin
				dat_next[endpoint_halt_pkg::AUTOCLEAR_POS] = autoclear_reg;
			end else if (sel_state) begin
				dat_next[NUM_EP-1:0] = internal_vec;
			end
		end
		if (cfg_wr) begin
			autoclear_next = wb_dat_i[endpoint_halt_pkg::AUTOCLEAR_POS];
		end
		if (soft_rst_i) begin
			autoclear_next = endpoint_halt_pkg::HALT_CFG_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
			autoclear_reg <= endpoint_halt_pkg::HALT_CFG_RESET;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			autoclear_reg <= autoclear_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// Token decision uses the halt bits as they stand when the token arrives
	assign tok_take = token_i.valid & (state_reg == endpoint_halt_pkg::ST_IDLE);
	assign tok_mask = ep_mask(token_i.ep);
	assign feat_mask = ep_mask(feature_i.ep);
	// Halted endpoint answers STALL; SETUP is never stalled
	assign stall_now = tok_take & ~token_i.setup & ((halt_byte & tok_mask) != '0);
	assign setup_ep0 = tok_take & token_i.setup & (token_i.ep == '0);

	generate
		for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
			localparam logic [EP_ID_W-1:0] EP_ID = EP_ID_W'(e);
			localparam int POS = halt_pos(e);
			logic hit;
			logic hw_clear;
			logic feat_hit;
			assign hit = token_i.ep == EP_ID;
			assign feat_hit = feature_i.valid & (feature_i.ep == EP_ID);
			assign hw_clear = (stall_now & hit & autoclear_reg) | ((e == 0) & setup_ep0);
			halt_bit_cell #(
				.ZERO_WRITE_OK(e != 0)
			) u_cell (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.soft_rst_i(soft_rst_i),
				.rd_i(halt_rd),
				.wr_i(halt_wr),
				.wbit_i(wb_dat_i[POS]),
				.hw_clear_i(hw_clear),
				.feat_clr_i(feat_hit & ~feature_i.set),
				.feat_set_i(feat_hit & feature_i.set),
				.stall_sent_i(stall_now & hit),
				.halt_o(halt_vec[e]),
				.internal_o(internal_vec[e])
			);
		end
	endgenerate

	// Tokens arriving while an answer is out are dropped; the core spaces them anyway
	always_comb begin
		state_next = state_reg;
		resp_valid_next = 1'b0;
		resp_stall_next = 1'b0;
		resp_ep_next = resp_ep_reg;
		case (state_reg)
			endpoint_halt_pkg::ST_IDLE: begin
				if (tok_take) begin
					state_next = endpoint_halt_pkg::ST_RESPOND;
					resp_valid_next = 1'b1;
					resp_stall_next = stall_now;
					resp_ep_next = token_i.ep;
				end
			end
			endpoint_halt_pkg::ST_RESPOND: begin
				state_next = endpoint_halt_pkg::ST_IDLE;
			end
			default: begin
				state_next = endpoint_halt_pkg::ST_IDLE;
			end
		endcase
		if (soft_rst_i) begin
			state_next = endpoint_halt_pkg::ST_IDLE;
			resp_valid_next = 1'b0;
			resp_stall_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= endpoint_halt_pkg::ST_IDLE;
			resp_valid_reg <= 1'b0;
			resp_stall_reg <= 1'b0;
			resp_ep_reg <= '0;
		end else begin
			state_reg <= state_next;
			resp_valid_reg <= resp_valid_next;
			resp_stall_reg <= resp_stall_next;
			resp_ep_reg <= resp_ep_next;
		end
	end

	assign resp_valid_o = resp_valid_reg;
	assign resp_stall_o = resp_stall_reg;
	assign resp_ep_o = resp_ep_reg;
	assign halt_bits_o = halt_byte;
	assign ep_stalled_o = internal_vec;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence stall_with_autoclear;
		stall_now && autoclear_reg && !halt_wr && !soft_rst_i;
	endsequence

	sequence halted_token;
		tok_take && !token_i.setup && ((halt_byte & tok_mask) != '0) && !soft_rst_i;
	endsequence

	reserved_bits_a: assert property ((halt_bits_o & endpoint_halt_pkg::HALT_CTRL_RSVD_MASK) == '0)
		else $error("reserved halt bit is set");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[DAT_W-1:REG_W] == '0)
		else $error("read data upper bits not zero");
	soft_reset_a: assert property (soft_rst_i |=> halt_bits_o == endpoint_halt_pkg::HALT_CTRL_RESET
		&& !autoclear_reg)
		else $error("software reset left halt bits set");
	stall_answer_a: assert property (halted_token |=> resp_valid_o && resp_stall_o
		&& resp_ep_o == $past(token_i.ep))
		else $error("halted endpoint not answered with STALL");
	no_stall_a: assert property (tok_take && ((halt_byte & tok_mask) == '0) && !soft_rst_i
		|=> resp_valid_o && !resp_stall_o)
		else $error("running endpoint answered with STALL");
	autoclear_a: assert property (stall_with_autoclear |=> (halt_bits_o & $past(tok_mask)) == '0)
		else $error("auto-clear did not drop halt bit");
	keep_halt_a: assert property (stall_now && !autoclear_reg && !soft_rst_i && !halt_wr
		&& !(feature_i.valid && !feature_i.set)
		|=> (halt_bits_o & $past(tok_mask)) != '0)
		else $error("halt bit lost without auto-clear");
	setup_clear_a: assert property (setup_ep0 && !halt_wr |=> !halt_bits_o[endpoint_halt_pkg::EP0_HALT_POS])
		else $error("SETUP did not clear endpoint 0 halt");
	resp_pulse_a: assert property (resp_valid_o |=> !resp_valid_o ##1 ($stable(resp_ep_o) || resp_valid_o))
		else $error("response held longer than one cycle");
	ack_pulse_a: assert property (wb_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse");

	// Host clear requests without a software halt register write or STALL in the same cycle; host set requests whatever else happens except a software reset
	sequence host_clear_alone;
		feature_i.valid && !feature_i.set && (feat_mask != '0) && !halt_wr && !stall_now && !soft_rst_i;
	endsequence

	sequence host_set_valid;
		feature_i.valid && feature_i.set && (feat_mask != '0) && !soft_rst_i;
	endsequence

	sequence unmapped_read;
		wb_take && !wb_we_i && !sel_halt && !sel_cfg && !sel_state;
	endsequence

	// Writes elsewhere, or without the low lane, must not touch the halt bits
	sequence foreign_write;
		wb_take && wb_we_i && !halt_wr && !stall_now && !setup_ep0 && !feature_i.valid && !soft_rst_i;
	endsequence

	unmapped_read_a: assert property (unmapped_read |=> wb_dat_o == '0)
		else $error("unmapped address read not zero");
	halt_readback_a: assert property (halt_rd |=> wb_dat_o[REG_W-1:0] == $past(halt_bits_o))
		else $error("read data differs from halt bits");
	cfg_set_a: assert property (cfg_wr && wb_dat_i[endpoint_halt_pkg::AUTOCLEAR_POS] && !soft_rst_i
		|=> autoclear_reg)
		else $error("auto-clear mode write lost");
	foreign_write_a: assert property (foreign_write |=> $stable(halt_bits_o))
		else $error("unrelated write changed halt bits");
	setup_nostall_a: assert property (tok_take && token_i.setup |=> !resp_stall_o)
		else $error("SETUP token answered with STALL");
	resp_origin_a: assert property (!tok_take |=> !resp_valid_o)
		else $error("answer without a taken token");
	internal_track_a: assert property (stall_now && !soft_rst_i |=> ep_stalled_o[$past(token_i.ep)])
		else $error("internal state not set by STALL");
	host_set_a: assert property (host_set_valid |=> ep_stalled_o[$past(feature_i.ep)])
		else $error("SetFeature did not mark endpoint stalled");
	host_clear_a: assert property (host_clear_alone
		|=> !ep_stalled_o[$past(feature_i.ep)] && (halt_bits_o & $past(feat_mask)) == '0)
		else $error("ClearFeature did not return endpoint to operation");
	ep0_zero_write_a: assert property (halt_wr && !wb_dat_i[endpoint_halt_pkg::EP0_HALT_POS]
		&& halt_bits_o[endpoint_halt_pkg::EP0_HALT_POS] && !soft_rst_i && !setup_ep0 && !stall_now
		&& !(feature_i.valid && !feature_i.set) |=> halt_bits_o[endpoint_halt_pkg::EP0_HALT_POS])
		else $error("zero write cleared endpoint 0 halt bit");
endmodule

/* tb/host_model.sv */
module host_model (
	input wire logic clk_i,
	output endpoint_halt_pkg::token_t token_o,
	output endpoint_halt_pkg::feature_t feature_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		token_o = '0;
		feature_o = '0;
	end

	task automatic send_token(input logic setup, input logic [2:0] ep);
		@(posedge clk_i);
		token_o <= '{valid: 1'b1, setup: setup, ep: ep};
		@(posedge clk_i);
		// Released fields flip so stale values cannot pass
		token_o <= '{valid: 1'b0, setup: ~setup, ep: ~ep};
	endtask

	task automatic send_feature(input logic set, input logic [2:0] ep);
		@(posedge clk_i);
		feature_o <= '{valid: 1'b1, set: set, ep: ep};
		@(posedge clk_i);
		feature_o <= '{valid: 1'b0, set: ~set, ep: ~ep};
		@(posedge clk_i);
	endtask
endmodule

/* tb/tb_endpoint_stall_control.sv */
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_endpoint_stall_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic soft_rst_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	endpoint_halt_pkg::token_t token_i;
	endpoint_halt_pkg::feature_t feature_i;
	logic resp_valid_o;
	logic resp_stall_o;
	logic [2:0] resp_ep_o;
	logic [7:0] halt_bits_o;
	logic [5:0] ep_stalled_o;
	logic [31:0] rd;
	int err_total = 0;
	int n_compared = 0;

	endpoint_stall_control endpoint_stall_control_i (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .token_i(token_i), .feature_i(feature_i),
		.resp_valid_o(resp_valid_o), .resp_stall_o(resp_stall_o), .resp_ep_o(resp_ep_o),
		.halt_bits_o(halt_bits_o), .ep_stalled_o(ep_stalled_o));
	host_model host_model_i (.clk_i(clk_i), .token_o(token_i), .feature_o(feature_i));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
		bit got;
		got = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d};
		for (int i = 0; i < 20 && !got; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) begin
				got = 1;
				rd = wb_dat_o;
			end
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (!got) begin
			err_total++;
			close_out();
		end
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [31:0] ex);
		wb(1'b0, a, 8'h00);
		`CHK("read data", ex, rd)
	endtask

	task automatic tok(input logic setup, input logic [2:0] ep, input logic stall);
		host_model_i.send_token(setup, ep);
		#1;
		`CHK("resp valid", 1'b1, resp_valid_o)
		`CHK("resp stall", stall, resp_stall_o)
		`CHK("resp ep", ep, resp_ep_o)
	endtask

	task automatic s_reset_map();
		chk_rd(4'h0, 32'h0000_0000);
		chk_rd(4'h4, 32'h0000_0000);
		chk_rd(4'h8, 32'h0000_0000);
		chk_rd(4'hC, 32'h0000_0000);
	endtask

	task automatic s_arm_write();
		wb(1'b0, 4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'hFF);
		chk_rd(4'h0, 32'h0000_007D);
		`CHK("halt bits", 8'h7D, halt_bits_o)
		wb(1'b1, 4'h0, 8'h00);
		chk_rd(4'h0, 32'h0000_0001);
		wb(1'b1, 4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h7C);
		chk_rd(4'h0, 32'h0000_0001);
	endtask

	task automatic s_stall();
		wb(1'b0, 4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h09);
		tok(1'b0, 3'd2, 1'b1);
		`CHK("internal ep2", 1'b1, ep_stalled_o[2])
		tok(1'b0, 3'd3, 1'b0);
		tok(1'b1, 3'd0, 1'b0);
		`CHK("ep0 halt", 8'h08, halt_bits_o)
	endtask

	task automatic s_autoclear();
		wb(1'b1, 4'h4, 8'h01);
		chk_rd(4'h4, 32'h0000_0001);
		tok(1'b0, 3'd2, 1'b1);
		`CHK("autocleared", 8'h00, halt_bits_o)
	endtask

	task automatic s_feature();
		wb(1'b0, 4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h20);
		host_model_i.send_feature(1'b1, 3'd4);
		`CHK("set feature", 6'h14, ep_stalled_o)
		host_model_i.send_feature(1'b0, 3'd4);
		`CHK("clear feature halt", 8'h00, halt_bits_o)
		`CHK("clear feature state", 6'h04, ep_stalled_o)
	endtask

	task automatic s_soft();
		wb(1'b0, 4'h0, 8'h00);
		wb(1'b1, 4'h0, 8'h04);
		`CHK("ep1 set", 8'h04, halt_bits_o)
		wb_sel_i <= 4'hE;
		wb(1'b1, 4'h0, 8'h00);
		wb_sel_i <= 4'h1;
		`CHK("lane gate", 8'h04, halt_bits_o)
		@(posedge clk_i);
		soft_rst_i <= 1'b1;
		@(posedge clk_i);
		soft_rst_i <= 1'b0;
		chk_rd(4'h0, 32'h0000_0000);
		chk_rd(4'h4, 32'h0000_0000);
		chk_rd(4'h8, 32'h0000_0000);
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		s_reset_map();
		s_arm_write();
		s_stall();
		s_autoclear();
		s_feature();
		s_soft();
		close_out();
	end
endmodule
